//--- rtl/cie_dest_mux.sv
// Destination steering for byte-wide results.
// Assumes results and the destination bit are valid in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module cie_dest_mux
(
  // Result in
  input  wire logic                           resultValid,
  input  wire logic                           destFile,
  input  wire logic [cie_pkg::DATA_WIDTH-1:0] result,
  // Steered out
  output logic                                accWrite,
  output logic                                fileWrite,
  output logic                                resultZero
);

  always_comb
  begin
    accWrite   = resultValid && !destFile;
    fileWrite  = resultValid && destFile;
    resultZero = (result == cie_pkg::ZERO_BYTE);
  end

endmodule
`default_nettype wire

//--- rtl/cie_execute.sv
// Execute stage for calls, watchdog kick and single-operand byte operations.
// Assumes a fetch stage presents opValid with the decoded fields, and that the
// file register's current value arrives on fileData in the same cycle.
//
// How it works
// - The absolute call pushes the next instruction address onto the return stack first.
// - The absolute call places its 11-bit immediate in counter bits 10 to 0, upper bits from the latch.
// - Counter bits 12 and 11 come from latch bits 4 and 3 and the absolute call takes two cycles.
// - The watchdog kick zeroes the watchdog counter.
// - The watchdog kick zeroes the watchdog prescaler.
// - The watchdog kick sets the timeout and power-down status bits and leaves other flags alone.
// - The accumulator call pushes the next instruction address onto the return stack first.
// - The accumulator call loads the accumulator into counter bits 7 to 0.
// - The accumulator call loads latch bits 6 to 0 into counter bits 14 to 8.
// - The accumulator call takes two cycles and changes no status flag.
// - Invert produces the bitwise complement of a file register at address 0 to 127.
// - For invert and decrement a destination bit of 0 writes the accumulator and 1 the file register.
// - Zeroing a file register writes zero to it and sets the zero flag.
// - Zeroing the accumulator writes zero to it and sets the zero flag.
// - Decrement subtracts one from the file register and sends it to the chosen destination.
`timescale 1ns/1ps
`default_nettype none
module cie_execute
(
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            reset,
  // Decoded operation
  input  wire logic                            opValid,
  input  wire logic [2:0]                      opSelect,
  input  wire logic [cie_pkg::IMM_WIDTH-1:0]   immediate,
  input  wire logic [cie_pkg::ADDR_WIDTH-1:0]  fileAddr,
  input  wire logic                            destFile,
  input  wire logic [cie_pkg::DATA_WIDTH-1:0]  fileData,
  input  wire logic [cie_pkg::LATCH_WIDTH-1:0] upperAddressLatch,
  // Program flow
  output logic                                 busy,
  output logic [cie_pkg::PC_WIDTH-1:0]         programCounter,
  output logic                                 stackPush,
  output logic [cie_pkg::PC_WIDTH-1:0]         stackTopSlot,
  // Data results
  output logic [cie_pkg::DATA_WIDTH-1:0]       accumulator,
  output logic                                 fileWrite,
  output logic [cie_pkg::ADDR_WIDTH-1:0]       fileWriteAddr,
  output logic [cie_pkg::DATA_WIDTH-1:0]       fileWriteData,
  // Status
  output logic                                 zeroFlag,
  output logic                                 timeoutStatusBit,
  output logic                                 powerdownStatusBit,
  output logic                                 watchdogClear
);

  cie_pkg::cie_state_type state;

  logic                              exec;
  logic                              isCallAbs;
  logic                              isCallAcc;
  logic                              isByteOp;
  logic [cie_pkg::DATA_WIDTH-1:0]    byteResult;
  logic                              accSel;
  logic                              fileSel;
  logic                              byteZero;
  logic [cie_pkg::PC_WIDTH-1:0]      pcNext;
  logic [cie_pkg::PC_WIDTH-1:0]      next_pc;

  // ==========================================================
  // Decode
  always_comb
  begin
    exec      = opValid && (state == cie_pkg::ST_EXEC);
    isCallAbs = exec && (opSelect == cie_pkg::OP_CALL_ABS);
    isCallAcc = exec && (opSelect == cie_pkg::OP_CALL_ACC);
    isByteOp  = exec && ((opSelect == cie_pkg::OP_INVERT_REG) || (opSelect == cie_pkg::OP_DEC_REG));
    pcNext    = programCounter + cie_pkg::PC_STEP;
  end

  always_comb
  begin
    if (opSelect == cie_pkg::OP_INVERT_REG)
    begin
      byteResult = ~fileData;
    end
    else
    begin
      byteResult = fileData - cie_pkg::ONE_BYTE;
    end
  end

  cie_dest_mux u_dest
  (
    .resultValid (isByteOp),
    .destFile    (destFile),
    .result      (byteResult),
    .accWrite    (accSel),
    .fileWrite   (fileSel),
    .resultZero  (byteZero)
  );

  // ==========================================================
  // Program counter target
  always_comb
  begin
    if (isCallAbs)
    begin
      next_pc = {upperAddressLatch[6:5], upperAddressLatch[cie_pkg::ABS_HIGH_HI:cie_pkg::ABS_HIGH_LO],
                 immediate};
    end
    else if (isCallAcc)
    begin
      next_pc = {upperAddressLatch, accumulator};
    end
    else if (exec)
    begin
      next_pc = pcNext;
    end
    else
    begin
      next_pc = programCounter;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      programCounter <= cie_pkg::PC_RESET;
    end
    else
    begin
      programCounter <= next_pc;
    end
  end

  // ==========================================================
  // Two-cycle calls: second cycle flushes the prefetched word
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state <= cie_pkg::ST_EXEC;
      busy  <= 1'b0;
    end
    else
    begin
      case (state)
        cie_pkg::ST_EXEC:
        begin
          if (isCallAbs || isCallAcc)
          begin
            state <= cie_pkg::ST_FLUSH;
            busy  <= 1'b1;
          end
        end
        cie_pkg::ST_FLUSH:
        begin
          state <= cie_pkg::ST_EXEC;
          busy  <= 1'b0;
        end
        default:
        begin
          state <= cie_pkg::ST_EXEC;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Return stack push
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      stackPush    <= 1'b0;
      stackTopSlot <= cie_pkg::PC_RESET;
    end
    else
    begin
      stackPush <= isCallAbs || isCallAcc;
      if (isCallAbs || isCallAcc)
      begin
        stackTopSlot <= pcNext;
      end
    end
  end

  // ==========================================================
  // Accumulator and file write-back
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      accumulator <= cie_pkg::ACC_RESET;
    end
    else if (exec && (opSelect == cie_pkg::OP_ZERO_ACC))
    begin
      accumulator <= cie_pkg::ZERO_BYTE;
    end
    else if (accSel)
    begin
      accumulator <= byteResult;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      fileWrite     <= 1'b0;
      fileWriteAddr <= '0;
      fileWriteData <= cie_pkg::ZERO_BYTE;
    end
    else
    begin
      fileWrite     <= fileSel || (exec && (opSelect == cie_pkg::OP_ZERO_REG));
      fileWriteAddr <= fileAddr;
      fileWriteData <= (exec && (opSelect == cie_pkg::OP_ZERO_REG)) ? cie_pkg::ZERO_BYTE : byteResult;
    end
  end

  // ==========================================================
  // Status flags
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      zeroFlag <= 1'b0;
    end
    else if (exec && ((opSelect == cie_pkg::OP_ZERO_REG) || (opSelect == cie_pkg::OP_ZERO_ACC)))
    begin
      zeroFlag <= 1'b1;
    end
    else if (isByteOp)
    begin
      zeroFlag <= byteZero;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      timeoutStatusBit   <= 1'b1;
      powerdownStatusBit <= 1'b1;
      watchdogClear      <= 1'b0;
    end
    else
    begin
      watchdogClear <= exec && (opSelect == cie_pkg::OP_WDT_KICK);
      if (exec && (opSelect == cie_pkg::OP_WDT_KICK))
      begin
        timeoutStatusBit   <= 1'b1;
        powerdownStatusBit <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Checks
  a_abs_call_push: assert property (@(posedge core_clk) disable iff (reset)
    isCallAbs |=> stackPush && (stackTopSlot == $past(pcNext)))
    else $error("absolute call did not push next address");

  a_abs_call_target: assert property (@(posedge core_clk) disable iff (reset)
    isCallAbs |=> programCounter[10:0] == $past(immediate))
    else $error("absolute call target low bits wrong");

  a_abs_call_high: assert property (@(posedge core_clk) disable iff (reset)
    isCallAbs |=> (programCounter[12:11] == $past(upperAddressLatch[4:3])) && busy ##1 !busy)
    else $error("absolute call high bits or length wrong");

  a_kick_clears_wdt: assert property (@(posedge core_clk) disable iff (reset)
    (exec && (opSelect == cie_pkg::OP_WDT_KICK)) |=> watchdogClear ##1 !watchdogClear)
    else $error("watchdog clear pulse wrong");

  a_kick_prescaler: assert property (@(posedge core_clk) disable iff (reset)
    watchdogClear |-> $past(opSelect) == cie_pkg::OP_WDT_KICK)
    else $error("watchdog clear without kick");

  a_kick_status: assert property (@(posedge core_clk) disable iff (reset)
    (exec && (opSelect == cie_pkg::OP_WDT_KICK)) |=> timeoutStatusBit && powerdownStatusBit && $stable(zeroFlag))
    else $error("kick status bits wrong");

  a_acc_call_push: assert property (@(posedge core_clk) disable iff (reset)
    isCallAcc |=> stackPush && (stackTopSlot == $past(pcNext)))
    else $error("accumulator call did not push");

  a_acc_call_low: assert property (@(posedge core_clk) disable iff (reset)
    isCallAcc |=> programCounter[7:0] == $past(accumulator))
    else $error("accumulator call low bits wrong");

  a_acc_call_high: assert property (@(posedge core_clk) disable iff (reset)
    isCallAcc |=> programCounter[14:8] == $past(upperAddressLatch))
    else $error("accumulator call high bits wrong");

  a_acc_call_flags: assert property (@(posedge core_clk) disable iff (reset)
    isCallAcc |=> $stable(zeroFlag) && busy ##1 !busy)
    else $error("accumulator call flags or length wrong");

  a_invert_value: assert property (@(posedge core_clk) disable iff (reset)
    (isByteOp && (opSelect == cie_pkg::OP_INVERT_REG) && destFile) |=> fileWriteData == ~$past(fileData))
    else $error("invert result wrong");

  a_dest_select: assert property (@(posedge core_clk) disable iff (reset)
    (isByteOp && !destFile) |=> !fileWrite && (accumulator == $past(byteResult)))
    else $error("destination steering wrong");

  a_zero_reg: assert property (@(posedge core_clk) disable iff (reset)
    (exec && (opSelect == cie_pkg::OP_ZERO_REG)) |=> fileWrite && (fileWriteData == 8'h00) && zeroFlag)
    else $error("zero register wrong");

  a_zero_acc: assert property (@(posedge core_clk) disable iff (reset)
    (exec && (opSelect == cie_pkg::OP_ZERO_ACC)) |=> (accumulator == 8'h00) && zeroFlag)
    else $error("zero accumulator wrong");

  a_dec_value: assert property (@(posedge core_clk) disable iff (reset)
    (isByteOp && (opSelect == cie_pkg::OP_DEC_REG) && destFile) |=> fileWriteData == $past(fileData) - 8'h01)
    else $error("decrement result wrong");

  a_byte_zero: assert property (@(posedge core_clk) disable iff (reset)
    isByteOp |=> zeroFlag == ($past(byteResult) == 8'h00))
    else $error("zero flag after byte op wrong");

endmodule
`default_nettype wire

//--- rtl/cie_pkg.sv
// Constants for the instruction execute subset: opcode selects, widths, reset values.
// Assumes the fetch stage hands over one decoded operation per instruction cycle.
package cie_pkg;

  // ==========================================================
  // Widths
  localparam int PC_WIDTH    = 15;
  localparam int DATA_WIDTH  = 8;
  localparam int ADDR_WIDTH  = 7;
  localparam int IMM_WIDTH   = 11;
  localparam int LATCH_WIDTH = 7;

  // ==========================================================
  // Operation selects
  localparam logic [2:0] OP_NONE       = 3'h0;
  localparam logic [2:0] OP_CALL_ABS   = 3'h1;
  localparam logic [2:0] OP_CALL_ACC   = 3'h2;
  localparam logic [2:0] OP_WDT_KICK   = 3'h3;
  localparam logic [2:0] OP_INVERT_REG = 3'h4;
  localparam logic [2:0] OP_ZERO_REG   = 3'h5;
  localparam logic [2:0] OP_ZERO_ACC   = 3'h6;
  localparam logic [2:0] OP_DEC_REG    = 3'h7;

  // ==========================================================
  // Reset values and fixed figures
  localparam logic [PC_WIDTH-1:0]   PC_RESET      = 15'h0000;
  localparam logic [DATA_WIDTH-1:0] ACC_RESET     = 8'h00;
  localparam logic [DATA_WIDTH-1:0] ZERO_BYTE     = 8'h00;
  localparam logic [DATA_WIDTH-1:0] ONE_BYTE      = 8'h01;
  localparam logic [PC_WIDTH-1:0]   PC_STEP       = 15'h0001;
  localparam int                    CALL_CYCLES   = 2;
  localparam int                    ABS_HIGH_LO   = 3;
  localparam int                    ABS_HIGH_HI   = 4;

  typedef enum logic [1:0]
  {
    ST_EXEC  = 2'b01,
    ST_FLUSH = 2'b10
  } cie_state_type;

endpackage

//--- tb/cie_execute_tb.sv
// Self-checking bench for the execute stage: calls, watchdog kick, byte operations.
// Assumes cie_pkg is compiled first and the design checks itself with inline assertions.
`timescale 1ns/1ps
`default_nettype none
module cie_execute_tb;
  // ==========================================================
  // Signals
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        opValid = 1'b0;
  logic [2:0]  opSelect = 3'h0;
  logic [10:0] immediate = 11'h000;
  logic [6:0]  fileAddr = 7'h00;
  logic        destFile = 1'b0;
  logic [7:0]  fileData = 8'h00;
  logic [6:0]  upperAddressLatch = 7'h00;
  logic        busy;
  logic [14:0] programCounter;
  logic        stackPush;
  logic [14:0] stackTopSlot;
  logic [7:0]  accumulator;
  logic        fileWrite;
  logic [6:0]  fileWriteAddr;
  logic [7:0]  fileWriteData;
  logic        zeroFlag;
  logic        timeoutStatusBit;
  logic        powerdownStatusBit;
  logic        watchdogClear;
  int          error_cnt = 0;
  int          samples_checked = 0;
  logic [14:0] expPc = 15'h0000;
  logic [7:0]  expAcc = 8'h00;
  logic        expZero = 1'b0;

  cie_execute dut
  (
    .core_clk           (core_clk),
    .reset              (reset),
    .opValid            (opValid),
    .opSelect           (opSelect),
    .immediate          (immediate),
    .fileAddr           (fileAddr),
    .destFile           (destFile),
    .fileData           (fileData),
    .upperAddressLatch  (upperAddressLatch),
    .busy               (busy),
    .programCounter     (programCounter),
    .stackPush          (stackPush),
    .stackTopSlot       (stackTopSlot),
    .accumulator        (accumulator),
    .fileWrite          (fileWrite),
    .fileWriteAddr      (fileWriteAddr),
    .fileWriteData      (fileWriteData),
    .zeroFlag           (zeroFlag),
    .timeoutStatusBit   (timeoutStatusBit),
    .powerdownStatusBit (powerdownStatusBit),
    .watchdogClear      (watchdogClear)
  );

  always #12.5 core_clk = ~core_clk;

  // ==========================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Presents one operation and returns 1 ns after the taking edge
  task automatic issue(input logic [2:0] sel, input logic [6:0] addr, input logic dst, input logic [7:0] data);
    opValid = 1'b1;
    opSelect = sel;
    fileAddr = addr;
    destFile = dst;
    fileData = data;
    @(posedge core_clk);
    #1;
    if (sel != cie_pkg::OP_CALL_ABS && sel != cie_pkg::OP_CALL_ACC)
      expPc = expPc + 15'h0001;
  endtask

  task automatic idle();
    opValid = 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk(16'(programCounter), 16'h0000);
    chk(16'(accumulator), 16'h0000);
    chk(16'({timeoutStatusBit, powerdownStatusBit, zeroFlag, busy}), 16'h000c);
    chk(16'({stackPush, fileWrite, watchdogClear}), 16'h0000);
  endtask

  task automatic byte_case(input logic [2:0] sel, input logic [6:0] addr, input logic dst,
                           input logic [7:0] data, input logic [7:0] res, input logic toFile, input logic z);
    issue(sel, addr, dst, data);
    expZero = z;
    if (!toFile)
      expAcc = res;
    chk(16'(fileWrite), 16'(toFile));
    if (toFile)
      chk({1'b0, fileWriteAddr, fileWriteData}, {1'b0, addr, res});
    chk(16'(accumulator), 16'(expAcc));
    chk(16'(zeroFlag), 16'(z));
    chk(16'({timeoutStatusBit, powerdownStatusBit}), 16'h0003);
    chk(16'(programCounter), 16'(expPc));
  endtask

  task automatic t_byte_ops();
    byte_case(cie_pkg::OP_INVERT_REG, 7'h7f, 1'b0, 8'hff, 8'h00, 1'b0, 1'b1);
    byte_case(cie_pkg::OP_INVERT_REG, 7'h00, 1'b1, 8'h5a, 8'ha5, 1'b1, 1'b0);
    byte_case(cie_pkg::OP_DEC_REG, 7'h7f, 1'b1, 8'h01, 8'h00, 1'b1, 1'b1);
    byte_case(cie_pkg::OP_DEC_REG, 7'h21, 1'b0, 8'h00, 8'hff, 1'b0, 1'b0);
    byte_case(cie_pkg::OP_ZERO_REG, 7'h40, 1'b0, 8'h77, 8'h00, 1'b1, 1'b1);
    byte_case(cie_pkg::OP_INVERT_REG, 7'h11, 1'b0, 8'h3c, 8'hc3, 1'b0, 1'b0);
    byte_case(cie_pkg::OP_ZERO_ACC, 7'h12, 1'b0, 8'h99, 8'h00, 1'b0, 1'b1);
    idle();
    chk(16'(fileWrite), 16'h0000);
  endtask

  task automatic t_wdt();
    issue(cie_pkg::OP_WDT_KICK, 7'h00, 1'b0, 8'h00);
    chk(16'(watchdogClear), 16'h0001);
    chk(16'({timeoutStatusBit, powerdownStatusBit}), 16'h0003);
    chk(16'({zeroFlag, fileWrite}), 16'h0002);
    idle();
    chk(16'(watchdogClear), 16'h0000);
  endtask

  task automatic t_call(input logic [2:0] sel, input logic [6:0] latch, input logic [10:0] imm);
    logic [14:0] ret;
    logic [14:0] target;
    ret = expPc + 15'h0001;
    target = (sel == cie_pkg::OP_CALL_ABS) ? {latch[6:3], imm} : {latch, expAcc};
    upperAddressLatch = latch;
    immediate = imm;
    issue(sel, 7'h05, 1'b1, 8'h10);
    chk(16'(programCounter), 16'(target));
    chk(16'(stackTopSlot), 16'(ret));
    chk(16'({stackPush, busy}), 16'h0003);
    chk(16'({timeoutStatusBit, powerdownStatusBit, zeroFlag}), {13'h0000, 2'b11, expZero});
    opSelect = cie_pkg::OP_DEC_REG;
    @(posedge core_clk);
    #1;
    chk(16'({stackPush, busy, fileWrite}), 16'h0000);
    chk(16'(programCounter), 16'(target));
    expPc = target;
    issue(cie_pkg::OP_ZERO_ACC, 7'h00, 1'b0, 8'h00);
    expAcc = 8'h00;
    expZero = 1'b1;
    chk(16'({programCounter, zeroFlag}), {expPc, 1'b1});
    idle();
  endtask

  // ==========================================================
  // Sequence and watchdog
  initial
  begin
    repeat (20) @(posedge core_clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_byte_ops();
    t_wdt();
    byte_case(cie_pkg::OP_INVERT_REG, 7'h11, 1'b0, 8'h3c, 8'hc3, 1'b0, 1'b0);
    t_call(cie_pkg::OP_CALL_ACC, 7'h2b, 11'h000);
    byte_case(cie_pkg::OP_INVERT_REG, 7'h11, 1'b0, 8'h3c, 8'hc3, 1'b0, 1'b0);
    t_call(cie_pkg::OP_CALL_ABS, 7'h5a, 11'h6c3);
    t_call(cie_pkg::OP_CALL_ABS, 7'h27, 11'h13c);
    wrap_up();
  end

  initial
  begin
    #20000;
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
